// ==== core/pscd_map.vh ====
`ifndef PSCD_MAP_VH
`define PSCD_MAP_VH
`define PSCD_TIE_GND 2'h0
`define PSCD_TIE_FAST 2'h1
`define PSCD_TIE_GIG 2'h2
`define PSCD_TIE_VDD 2'h3
`define PSCD_SETUP_SINGLE 5'h17
`define PSCD_SETUP_MULTI 5'h18
`define PSCD_SETUP_SLAVE 5'h19
`define PSCD_SETUP_MASTER 5'h1a
`define PSCD_MS_SINGLE 5'h03
`define PSCD_MS_MULTI 5'h0f
`define PSCD_MS_SLAVE 5'h13
`define PSCD_MS_MASTER 5'h1f
`define PSCD_ADV_ALL 4'hf
`define PSCD_CTRL_AN_BIT12 1'h1
`define PSCD_CTRL_BIT13 1'h0
`define PSCD_CTRL_BIT6 1'h1
`define PSCD_ADDR_RST 5'h00
`define PSCD_SETUP_RST 5'h17
`define PSCD_SETUP_MSB 4'hf
`define PSCD_SETUP_LSB 4'hb
`define PSCD_CTRL_SPEED_LO_POS 4'hd
`define PSCD_CTRL_AN_POS 4'hc
`define PSCD_CTRL_DUPLEX_POS 4'h8
`define PSCD_CTRL_SPEED_HI_POS 4'h6
`define PSCD_CTRL_BIT8 1'h0
`define PSCD_ADV_PAUSE_POS 4'ha
`define PSCD_ADV_MSB 4'h8
`define PSCD_ADV_LSB 4'h5
`define PSCD_MS_MSB 4'hc
`define PSCD_MS_LSB 4'h8
`endif

// ==== core/pscd_pin_decode.v ====
`include "pscd_map.vh"

// pure decode of the tie values; the caller latches the result once
module pscd_pin_decode (
    input wire [1:0] addr_low_tie_in,
    input wire [1:0] addr_high_tie_in,
    input wire [1:0] setup_low_tie_in,
    input wire [1:0] setup_high_tie_in,
    output reg [2:0] addr_out,
    output reg pause_out,
    output reg [4:0] setup_out,
    output reg setup_valid_out
);
    always @* begin
        pause_out = addr_high_tie_in[1]; // [R05]
        addr_out = {addr_high_tie_in[0], addr_low_tie_in}; // [R05] [R06] [R03]
        setup_valid_out = (setup_high_tie_in == `PSCD_TIE_GIG);
        case (setup_low_tie_in) // [R07]
            `PSCD_TIE_GND: setup_out = `PSCD_SETUP_SINGLE;
            `PSCD_TIE_FAST: setup_out = `PSCD_SETUP_MULTI;
            `PSCD_TIE_GIG: setup_out = `PSCD_SETUP_SLAVE;
            default: setup_out = `PSCD_SETUP_MASTER;
        endcase
    end
endmodule

// ==== core/pscd_strap_decoder.v ====
`include "pscd_map.vh"

// Notes on behaviour
// [R01] each configuration pin arrives as a two-bit tie value: 0 ground, 1 fast, 2 gig, 3 supply.
// [R02] the four pins are sampled once, on the first clock after hardware reset is released.
// [R03] pin ties alone select any management address from 0 to 7.
// [R04] addresses above 7 come only from a software write of the five-bit address field.
// [R05] the address-high pin sets pause from its upper bit and address bit 2 from its lower bit.
// [R06] the address-low tie value is address bits 1:0 in binary.
// [R07] mode-high at 2 with mode-low 0..3 loads the setup field with 10111..11010; else reserved.
// [R08] the setup field (register 19 bits 15:11) is loaded right after reset from the mode pins.
// [R09] valid setup presets control bits 13,12,6 to 0,1,1 and all four speed advert bits to 1.
// [R10] master/slave bits 12:8 are 00011, 01111, 10011 or 11111 by setup value.
// [R11] a software reset keeps the current values and never looks at the pins.
// [R12] a software write of the setup field does not re-derive any dependent bit.
// [R13] the power-down pin gates every function except the management interface.
// [R14] control, advert and master/slave values are 16-bit register images writable over the management interface.
// [R15] decoded values hold between hardware resets except for explicit software writes.
module pscd_strap_decoder (
    input wire REF_CLK_IN,
    input wire RESET_IN,
    input wire [1:0] ADDR_LOW_SELECT_PIN_IN,
    input wire [1:0] ADDR_HIGH_PAUSE_PIN_IN,
    input wire [1:0] SETUP_LOW_SELECT_PIN_IN,
    input wire [1:0] SETUP_HIGH_SELECT_PIN_IN,
    input wire HW_POWERDOWN_PIN_IN,
    input wire SW_RESET_IN,
    input wire ADDR_WR_IN,
    input wire [4:0] ADDR_WDATA_IN,
    input wire SETUP_WR_IN,
    input wire [4:0] SETUP_WDATA_IN,
    input wire CTRL_WR_IN,
    input wire [15:0] CTRL_WDATA_IN,
    input wire ADV_WR_IN,
    input wire [15:0] ADV_WDATA_IN,
    input wire MS_WR_IN,
    input wire [15:0] MS_WDATA_IN,
    output reg [4:0] MGMT_STATION_ADDRESS_OUT,
    output reg PAUSE_ADV_OUT,
    output reg [15:0] SETUP_REG_OUT,
    output reg [15:0] CTRL_REG_OUT,
    output reg [15:0] ADV_REG_OUT,
    output reg [15:0] MS_REG_OUT,
    output reg SETUP_RESERVED_OUT,
    output reg CONFIG_DONE_OUT,
    output reg FUNC_ENABLE_OUT,
    output reg MGMT_ENABLE_OUT
);
    localparam [1:0] ST_RESET = 2'h0;
    localparam [1:0] ST_SAMPLE = 2'h1;
    localparam [1:0] ST_RUN = 2'h2;

    reg [1:0] state_q;
    reg [1:0] state_d;
    wire strap_edge;
    wire [2:0] dec_addr;
    wire dec_pause;
    wire [4:0] dec_setup;
    wire dec_valid;
    reg [4:0] ms_preset;
    reg [4:0] setup_preset;
    reg [15:0] setup_image;
    reg [15:0] ctrl_image;
    reg [15:0] adv_image;
    reg [15:0] ms_image;
    reg [4:0] addr_d;
    reg pause_d;
    reg [15:0] setup_d;
    reg [15:0] ctrl_d;
    reg [15:0] adv_d;
    reg [15:0] ms_d;
    reg reserved_d;
    reg done_d;
    reg func_en_d;
    reg mgmt_en_d;

    // pins are treated as synchronous; decode is combinational and only the sample edge uses it
    pscd_pin_decode pscd_pin_decode_i (
        .addr_low_tie_in(ADDR_LOW_SELECT_PIN_IN), // [R01]
        .addr_high_tie_in(ADDR_HIGH_PAUSE_PIN_IN),
        .setup_low_tie_in(SETUP_LOW_SELECT_PIN_IN),
        .setup_high_tie_in(SETUP_HIGH_SELECT_PIN_IN),
        .addr_out(dec_addr),
        .pause_out(dec_pause),
        .setup_out(dec_setup),
        .setup_valid_out(dec_valid)
    );

    // the reset state lasts exactly one edge after release, which is the only strap edge
    assign strap_edge = (state_q == ST_RESET); // [R02]

    always @* begin
        state_d = ST_RESET;
        case (state_q)
            ST_RESET: begin
                state_d = ST_SAMPLE;
            end
            ST_SAMPLE: begin
                state_d = ST_RUN;
            end
            ST_RUN: begin
                state_d = ST_RUN; // [R15]
                if (SW_RESET_IN) begin
                    // a soft reset must never walk back into the strap edge
                    state_d = ST_RUN; // [R11]
                end
            end
            default: begin
                state_d = ST_RESET;
            end
        endcase
    end

    always @* begin
        case (dec_setup) // [R10]
            `PSCD_SETUP_SINGLE: ms_preset = `PSCD_MS_SINGLE;
            `PSCD_SETUP_MULTI: ms_preset = `PSCD_MS_MULTI;
            `PSCD_SETUP_SLAVE: ms_preset = `PSCD_MS_SLAVE;
            default: ms_preset = `PSCD_MS_MASTER;
        endcase
        if (!dec_valid) begin
            // reserved straps fall back to the single-port image, like the setup field does
            ms_preset = `PSCD_MS_SINGLE;
        end
    end

    // preset images for the strap edge; every bit without a preset starts at zero
    always @* begin
        setup_preset = dec_valid ? dec_setup : `PSCD_SETUP_RST; // [R07]
        setup_image = 16'h0000;
        setup_image[`PSCD_SETUP_MSB:`PSCD_SETUP_LSB] = setup_preset; // [R08]
        ctrl_image = 16'h0000;
        ctrl_image[`PSCD_CTRL_SPEED_LO_POS] = `PSCD_CTRL_BIT13; // [R09]
        ctrl_image[`PSCD_CTRL_AN_POS] = `PSCD_CTRL_AN_BIT12; // [R09]
        // bit 8 has its own explicit preset, PSCD_CTRL_BIT8, which is zero, so the strap edge loads it as 0
        ctrl_image[`PSCD_CTRL_DUPLEX_POS] = `PSCD_CTRL_BIT8;
        ctrl_image[`PSCD_CTRL_SPEED_HI_POS] = `PSCD_CTRL_BIT6; // [R09]
        adv_image = 16'h0000;
        adv_image[`PSCD_ADV_MSB:`PSCD_ADV_LSB] = `PSCD_ADV_ALL; // [R09]
        adv_image[`PSCD_ADV_PAUSE_POS] = dec_pause; // [R05]
        ms_image = 16'h0000;
        ms_image[`PSCD_MS_MSB:`PSCD_MS_LSB] = ms_preset; // [R10]
    end

    // the strap load wins over a write in the same cycle; writes count from the next edge on
    always @* begin
        addr_d = MGMT_STATION_ADDRESS_OUT; // [R15]
        pause_d = PAUSE_ADV_OUT;
        setup_d = SETUP_REG_OUT;
        ctrl_d = CTRL_REG_OUT;
        adv_d = ADV_REG_OUT;
        ms_d = MS_REG_OUT;
        reserved_d = SETUP_RESERVED_OUT;
        if (strap_edge) begin
            addr_d = {2'b00, dec_addr}; // [R03] [R05] [R06]
            pause_d = dec_pause; // [R05]
            setup_d = setup_image; // [R08]
            ctrl_d = ctrl_image; // [R09]
            adv_d = adv_image; // [R09]
            ms_d = ms_image; // [R10]
            reserved_d = ~dec_valid; // [R07]
        end else begin
            if (ADDR_WR_IN) begin
                // the only way to reach an address above 7
                addr_d = ADDR_WDATA_IN; // [R04]
            end
            if (SETUP_WR_IN) begin
                // dependent images stay put: derivation belongs to hardware reset alone
                setup_d = 16'h0000;
                setup_d[`PSCD_SETUP_MSB:`PSCD_SETUP_LSB] = SETUP_WDATA_IN; // [R12]
            end
            if (CTRL_WR_IN) begin
                ctrl_d = CTRL_WDATA_IN; // [R14]
            end
            if (ADV_WR_IN) begin
                // the pause output mirrors its bit of the advertisement image
                adv_d = ADV_WDATA_IN; // [R14]
                pause_d = ADV_WDATA_IN[`PSCD_ADV_PAUSE_POS];
            end
            if (MS_WR_IN) begin
                ms_d = MS_WDATA_IN; // [R14]
            end
        end
    end

    always @* begin
        done_d = ~strap_edge;
        mgmt_en_d = 1'b1; // [R13]
        func_en_d = ~HW_POWERDOWN_PIN_IN & ~strap_edge; // [R13]
    end

    always @(posedge REF_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            state_q <= ST_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    // only hardware reset clears these; a soft reset leaves the register contents in charge
    always @(posedge REF_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            MGMT_STATION_ADDRESS_OUT <= `PSCD_ADDR_RST;
            PAUSE_ADV_OUT <= 1'b0;
            SETUP_REG_OUT <= 16'h0000;
            CTRL_REG_OUT <= 16'h0000;
            ADV_REG_OUT <= 16'h0000;
            MS_REG_OUT <= 16'h0000;
            SETUP_RESERVED_OUT <= 1'b0;
            CONFIG_DONE_OUT <= 1'b0;
        end else begin
            MGMT_STATION_ADDRESS_OUT <= addr_d;
            PAUSE_ADV_OUT <= pause_d;
            SETUP_REG_OUT <= setup_d;
            CTRL_REG_OUT <= ctrl_d;
            ADV_REG_OUT <= adv_d;
            MS_REG_OUT <= ms_d;
            SETUP_RESERVED_OUT <= reserved_d;
            CONFIG_DONE_OUT <= done_d;
        end
    end

    // the management side comes up regardless of power-down so software can still get in
    always @(posedge REF_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            FUNC_ENABLE_OUT <= 1'b0;
            MGMT_ENABLE_OUT <= 1'b0;
        end else begin
            FUNC_ENABLE_OUT <= func_en_d;
            MGMT_ENABLE_OUT <= mgmt_en_d;
        end
    end
endmodule

// ==== tb/pscd_board.sv ====
module pscd_board (
    input wire logic [7:0] sel_in,
    output logic [1:0] low_out, high_out, slow_out, shigh_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // hard ties never move on their own, so the pins stand still
    assign {shigh_out, slow_out, high_out, low_out} = sel_in;
endmodule

// ==== tb/pscd_chk_sv_chk.sv ====
module pscd_chk (
    input wire REF_CLK_IN, RESET_IN, HW_POWERDOWN_PIN_IN, ADDR_WR_IN, CTRL_WR_IN, ADV_WR_IN,
    input wire MS_WR_IN, PAUSE_ADV_OUT, SETUP_RESERVED_OUT, CONFIG_DONE_OUT, MGMT_ENABLE_OUT,
    input wire FUNC_ENABLE_OUT, SETUP_WR_IN,
    input wire [1:0] ADDR_LOW_SELECT_PIN_IN, ADDR_HIGH_PAUSE_PIN_IN, SETUP_LOW_SELECT_PIN_IN,
    input wire [1:0] SETUP_HIGH_SELECT_PIN_IN,
    input wire [4:0] ADDR_WDATA_IN, MGMT_STATION_ADDRESS_OUT, SETUP_WDATA_IN,
    input wire [15:0] SETUP_REG_OUT, CTRL_REG_OUT, ADV_REG_OUT, MS_REG_OUT,
    input wire [15:0] CTRL_WDATA_IN, ADV_WDATA_IN, MS_WDATA_IN
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge REF_CLK_IN); endclocking
    default disable iff (RESET_IN);
    wire [4:0] f = SETUP_REG_OUT[15:11];
    sequence s_load;
        $rose(MGMT_ENABLE_OUT);
    endsequence
    chk_addr_load: assert property (s_load |-> MGMT_STATION_ADDRESS_OUT ==
        {2'h0, $past(ADDR_HIGH_PAUSE_PIN_IN[0]), $past(ADDR_LOW_SELECT_PIN_IN)})
        else $error("address load wrong");
    chk_pause_load: assert property (s_load |-> PAUSE_ADV_OUT ==
        $past(ADDR_HIGH_PAUSE_PIN_IN[1]) && ADV_REG_OUT[10] == PAUSE_ADV_OUT
        && ADV_REG_OUT[8:5] == 4'hf) else $error("pause load wrong");
    chk_setup_load: assert property (s_load |-> f ==
        (($past(SETUP_HIGH_SELECT_PIN_IN) == 2'h2) ? 5'h17 + $past(SETUP_LOW_SELECT_PIN_IN)
        : 5'h17)) else $error("setup load wrong");
    chk_ctrl_load: assert property (s_load |-> CTRL_REG_OUT == 16'h1040 &&
        SETUP_RESERVED_OUT == ($past(SETUP_HIGH_SELECT_PIN_IN) != 2'h2))
        else $error("control load wrong");
    chk_ms_load: assert property (s_load |-> MS_REG_OUT == {3'h0,
        (($past(SETUP_HIGH_SELECT_PIN_IN) != 2'h2) ? 5'h03
        : ($past(SETUP_LOW_SELECT_PIN_IN) == 2'h0) ? 5'h03
        : ($past(SETUP_LOW_SELECT_PIN_IN) == 2'h1) ? 5'h0f
        : ($past(SETUP_LOW_SELECT_PIN_IN) == 2'h2) ? 5'h13 : 5'h1f), 8'h00})
        else $error("ms load wrong");
    chk_addr_write: assert property (CONFIG_DONE_OUT && ADDR_WR_IN |=>
        MGMT_STATION_ADDRESS_OUT == $past(ADDR_WDATA_IN)) else $error("address write lost");
    chk_addr_hold: assert property (CONFIG_DONE_OUT && !ADDR_WR_IN |=>
        $stable(MGMT_STATION_ADDRESS_OUT)) else $error("address moved");
    chk_deps_hold: assert property (CONFIG_DONE_OUT && !(CTRL_WR_IN | ADV_WR_IN | MS_WR_IN)
        |=> $stable(CTRL_REG_OUT) && $stable(ADV_REG_OUT) && $stable(MS_REG_OUT)
        && $stable(PAUSE_ADV_OUT)) else $error("dependent bits moved");
    chk_setup_write: assert property (CONFIG_DONE_OUT && SETUP_WR_IN |=>
        SETUP_REG_OUT == {$past(SETUP_WDATA_IN), 11'h000}) else $error("setup write lost");
    chk_ctrl_write: assert property (CONFIG_DONE_OUT && CTRL_WR_IN |=>
        CTRL_REG_OUT == $past(CTRL_WDATA_IN)) else $error("control write lost");
    chk_adv_write: assert property (CONFIG_DONE_OUT && ADV_WR_IN |=>
        ADV_REG_OUT == $past(ADV_WDATA_IN) && PAUSE_ADV_OUT == $past(ADV_WDATA_IN[10]))
        else $error("advert write lost");
    chk_ms_write: assert property (CONFIG_DONE_OUT && MS_WR_IN |=>
        MS_REG_OUT == $past(MS_WDATA_IN)) else $error("ms write lost");
    chk_power_gate: assert property (CONFIG_DONE_OUT |-> MGMT_ENABLE_OUT &&
        FUNC_ENABLE_OUT == !$past(HW_POWERDOWN_PIN_IN)) else $error("power gating wrong");
endmodule
bind pscd_strap_decoder pscd_chk pscd_chk_i (.*);

// ==== tb/pscd_strap_decoder_test.sv ====
module pscd_strap_decoder_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst = 1, pd = 0, swr = 0, awr = 0, stw = 0, cwr = 0, avw = 0, mwr = 0;
    logic [7:0] tie = 0;
    logic [4:0] ad = 0, sd = 0;
    logic [15:0] wd = 0;
    logic [31:0] s = 76;
    logic [59:0] q[$];
    logic [59:0] e;
    logic done_seen = 0;
    int n_fail = 0, checks_done = 0;
    wire [1:0] pl, ph, sl, sh;
    wire [4:0] addr;
    wire [15:0] sreg, creg, areg, mreg;
    wire pause, rsv, done;
    wire [59:0] got = {addr, pause, sreg, creg, areg, mreg[12:8], rsv};
    initial forever #20 clk = ~clk;
    pscd_board pscd_board_i (.sel_in(tie), .low_out(pl), .high_out(ph), .slow_out(sl),
        .shigh_out(sh));
    pscd_strap_decoder pscd_strap_decoder_i (.REF_CLK_IN(clk), .RESET_IN(rst),
        .ADDR_LOW_SELECT_PIN_IN(pl), .ADDR_HIGH_PAUSE_PIN_IN(ph), .SETUP_LOW_SELECT_PIN_IN(sl),
        .SETUP_HIGH_SELECT_PIN_IN(sh), .HW_POWERDOWN_PIN_IN(pd), .SW_RESET_IN(swr),
        .ADDR_WR_IN(awr), .ADDR_WDATA_IN(ad), .SETUP_WR_IN(stw), .SETUP_WDATA_IN(sd),
        .CTRL_WR_IN(cwr), .CTRL_WDATA_IN(wd), .ADV_WR_IN(avw), .ADV_WDATA_IN(wd),
        .MS_WR_IN(mwr), .MS_WDATA_IN(wd), .MGMT_STATION_ADDRESS_OUT(addr), .PAUSE_ADV_OUT(pause),
        .SETUP_REG_OUT(sreg), .CTRL_REG_OUT(creg), .ADV_REG_OUT(areg), .MS_REG_OUT(mreg),
        .SETUP_RESERVED_OUT(rsv), .CONFIG_DONE_OUT(done), .FUNC_ENABLE_OUT(),
        .MGMT_ENABLE_OUT());
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction
    function automatic logic [59:0] expv(input logic [7:0] t);
        logic [4:0] f;
        f = (t[7:6] == 2'h2) ? 5'h17 + t[5:4] : 5'h17;
        return {2'h0, t[2], t[1:0], t[3], f, 11'h0, 16'h1040, 16'h01e0 | {5'h0, t[3], 10'h0},
            f == 5'h17 ? 5'h03 : f == 5'h18 ? 5'h0f : f == 5'h19 ? 5'h13 : 5'h1f, t[7:6] != 2'h2};
    endfunction
    task end_of_test;
        $display("checks %0d fails %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // look on the falling edge after done rises, one and a half cycles after the load edge, so the outputs have settled
    always @(negedge clk) begin
        done_seen <= done;
        if (done && !done_seen) begin
            e = q.pop_front();
            checks_done++;
            if (got !== e) begin
                n_fail++;
                $display("[ERR] strap load exp %h got %h", e, got);
            end
        end
    end
    initial begin
        #16000;
        n_fail++;
        end_of_test;
    end
    initial begin
        repeat (16) @(posedge clk);
        // first half walks all eight addresses and all four valid setups
        for (int i = 0; i < 16; i++) begin
            s = xs(s);
            tie <= {i[3] ? s[7:6] : 2'h2, i[1:0], s[0], i[2], i[1:0]};
            rst <= 1;
            pd <= s[9];
            @(posedge clk);
            rst <= 0;
            q.push_back(expv(tie));
            repeat (3) @(posedge clk);
            // pins move and a soft reset lands while writes go in; none may reload the straps
            tie <= ~tie;
            swr <= 1;
            {awr, ad, stw, sd} <= {1'b1, s[14:10], 1'b1, s[19:15]};
            {cwr, avw, mwr, wd} <= {{3{i[0]}}, s[31:16]};
            @(posedge clk);
            {swr, awr, stw, cwr, avw, mwr} <= 0;
            repeat (3) @(posedge clk);
            $display("test %0d done", i);
        end
        end_of_test;
    end
endmodule
